// >>> pkg/gpa_pkg.sv
package gpa_pkg;

  // port geometry
  localparam int unsigned PORT_WIDTH   = 5;
  localparam int unsigned SHARED_BIT   = 4;
  localparam int unsigned ANALOG_PINS  = 4;
  localparam int unsigned CFG_WIDTH    = 4;

  // reset values
  localparam logic [4:0] DATA_RST     = 5'h00;
  localparam logic [4:0] DIR_RST      = 5'h1F;
  localparam logic [3:0] ANALOG_RST   = 4'hF;
  localparam logic [3:0] CFG_RST      = 4'h0;

  // core side access to the port
  typedef struct packed {
    logic       data_wr;
    logic [4:0] data_wmask;
    logic [4:0] data_wval;
    logic       dir_wr;
    logic [4:0] dir_wdata;
    logic       cfg_wr;
    logic [3:0] cfg_wdata;
  } gpa_core_req_s;

  // pin side drive
  typedef struct packed {
    logic [4:0] out;
    logic [4:0] oe;
  } gpa_pin_drv_s;

endpackage

// >>> hw/gpa_sync.sv
`timescale 1ns/1ps
module gpa_sync #(
  parameter int unsigned WIDTH = 5
) (
  input  wire logic             clk_sys, // core clock
  input  wire logic             rst,     // async reset, active high
  input  wire logic [WIDTH-1:0] din,     // asynchronous pin levels
  output logic      [WIDTH-1:0] dout     // levels in clk_sys domain
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] dout_d;

  // a zero-width port leaves nothing to synchronise
  if (WIDTH == 0) begin : g_width_check
    $error("synchroniser width must be at least one");
  end

  // first stage is read only by the second stage
  always_comb begin
    meta_d = din;
    dout_d = meta_q;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= meta_d;
      dout   <= dout_d;
    end
  end

endmodule

// >>> hw/gpa_port.sv
`timescale 1ns/1ps
module gpa_port (
  input  wire logic                  clk_sys,          // core clock, 100 MHz
  input  wire logic                  rst,              // power-on reset, async, active high
  input  wire gpa_pkg::gpa_core_req_s core_req,        // core writes, same clock
  input  wire logic                  timer_ext_clk_en, // timer owns the shared pin
  input  wire logic [4:0]            pin_in,           // raw pin levels
  output gpa_pkg::gpa_pin_drv_s      pin_drv,          // pin outputs and enables
  output logic [4:0]                 port_a_data,      // digital read value
  output logic [4:0]                 port_a_direction, // direction register
  output logic [4:0]                 port_a_latch,     // output latch contents
  output logic [3:0]                 analog_sel,       // pins routed to analog
  output logic                       timer_external_clock_input // synced timer clock
);

  // analog pins are assumed left as inputs by software

  logic [4:0] pins_sync;
  logic [4:0] latch_q;
  logic [4:0] latch_d;
  logic [4:0] dir_q;
  logic [4:0] dir_d;
  logic [3:0] cfg_q;
  logic [3:0] cfg_d;
  logic [3:0] analog_d;
  logic [4:0] rd_d;
  logic [4:0] drv_out_d;
  logic [4:0] drv_oe_d;
  logic       tclk_d;

  // pins cross into the core clock before anything reads them
  gpa_sync #(
    .WIDTH (gpa_pkg::PORT_WIDTH)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (pin_in),
    .dout    (pins_sync)
  );

  // the merge and drive logic below is written for exactly this pin count
  if (gpa_pkg::PORT_WIDTH != 5 || gpa_pkg::ANALOG_PINS != 4) begin : g_width_check
    $error("port geometry does not match the logic");
  end

  // register next values; config and direction writes are plain stores
  always_comb begin
    latch_d = latch_q;
    dir_d   = dir_q;
    cfg_d   = cfg_q;
    if (core_req.data_wr) begin
      latch_d = (pins_sync & ~core_req.data_wmask) |
                (core_req.data_wval & core_req.data_wmask);
    end
    if (core_req.dir_wr) begin
      dir_d = core_req.dir_wdata;
    end
    if (core_req.cfg_wr) begin
      cfg_d = core_req.cfg_wdata;
    end
  end

  // the latch, direction and config registers; direction resets to inputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      latch_q <= gpa_pkg::DATA_RST;
      dir_q   <= gpa_pkg::DIR_RST;
      cfg_q   <= gpa_pkg::CFG_RST;
    end else begin
      latch_q <= latch_d;
      dir_q   <= dir_d;
      cfg_q   <= cfg_d;
    end
  end

  // pin drive and read path; config value zero means all analog
  always_comb begin
    // per-pin analog select, set bit means analog
    analog_d = ~cfg_q;
    // reads see pins, analog bits read zero
    rd_d = pins_sync & {1'b1, ~analog_d};
    drv_out_d = latch_q;
    drv_oe_d  = ~dir_q;
    drv_out_d[gpa_pkg::SHARED_BIT] = 1'b0;
    drv_oe_d[gpa_pkg::SHARED_BIT]  = ~dir_q[gpa_pkg::SHARED_BIT] &
                                     ~latch_q[gpa_pkg::SHARED_BIT];
    // timer owns pin four when enabled
    if (timer_ext_clk_en) begin
      drv_oe_d[gpa_pkg::SHARED_BIT] = 1'b0;
    end
    tclk_d = pins_sync[gpa_pkg::SHARED_BIT] & timer_ext_clk_en;
  end

  // all outputs leave from flip-flops; adds one cycle on the pins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_drv                    <= '0;
      port_a_data                <= '0;
      port_a_direction           <= gpa_pkg::DIR_RST;
      port_a_latch               <= gpa_pkg::DATA_RST;
      analog_sel                 <= gpa_pkg::ANALOG_RST;
      timer_external_clock_input <= 1'b0;
    end else begin
      pin_drv.out                <= drv_out_d;
      pin_drv.oe                 <= drv_oe_d;
      port_a_data                <= rd_d;
      port_a_direction           <= dir_q;
      port_a_latch               <= latch_q;
      analog_sel                 <= analog_d;
      timer_external_clock_input <= tclk_d;
    end
  end

  property p_rmw;
    @(posedge clk_sys) disable iff (rst)
    core_req.data_wr |=> latch_q == (($past(pins_sync) & ~$past(core_req.data_wmask)) |
                         ($past(core_req.data_wval) & $past(core_req.data_wmask)));
  endproperty
  a_rmw: assert property (p_rmw) else $error("latch not merged from pins");

  property p_hiz;
    @(posedge clk_sys) disable iff (rst)
    (dir_q[0] && dir_q[3]) |=> !pin_drv.oe[0] && !pin_drv.oe[3];
  endproperty
  a_hiz: assert property (p_hiz) else $error("driver on while input");

  property p_drive;
    @(posedge clk_sys) disable iff (rst)
    !dir_q[1] |=> pin_drv.oe[1] && pin_drv.out[1] == $past(latch_q[1]);
  endproperty
  a_drive: assert property (p_drive) else $error("output pin not driven from latch");

  property p_read;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> port_a_data[4] == $past(pins_sync[4]);
  endproperty
  a_read: assert property (p_read) else $error("read not from pin");

  property p_od;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> !(pin_drv.oe[4] && pin_drv.out[4]) && !(pin_drv.oe[4] && $past(latch_q[4]));
  endproperty
  a_od: assert property (p_od) else $error("shared pin driven high");

  property p_analog_zero;
    @(posedge clk_sys) disable iff (rst)
    analog_sel[2] |-> port_a_data[2] == 1'b0;
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero");

  property p_cfg;
    @(posedge clk_sys) disable iff (rst)
    core_req.cfg_wr ##1 !core_req.cfg_wr |=> analog_sel == ~$past(cfg_q);
  endproperty
  a_cfg: assert property (p_cfg) else $error("analog select mismatch");

  property p_periph;
    @(posedge clk_sys) disable iff (rst)
    timer_ext_clk_en |=> !pin_drv.oe[4];
  endproperty
  a_periph: assert property (p_periph) else $error("port drives timer pin");

  property p_dir_analog;
    @(posedge clk_sys) disable iff (rst)
    (analog_sel[0] && !dir_q[0]) |=> pin_drv.oe[0];
  endproperty
  a_dir_analog: assert property (p_dir_analog) else $error("direction ignored");

  property p_latch_hold;
    @(posedge clk_sys) disable iff (rst)
    !core_req.data_wr |=> $stable(latch_q);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed");

  property p_dir_reset;
    @(posedge clk_sys) $fell(rst) |-> dir_q == gpa_pkg::DIR_RST;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not reset");

  property p_od_low;
    @(posedge clk_sys) disable iff (rst)
    pin_drv.oe[4] |-> !pin_drv.out[4];
  endproperty
  a_od_low: assert property (p_od_low) else $error("shared pin output not low");

  property p_od_release;
    @(posedge clk_sys) disable iff (rst)
    latch_q[4] |=> !pin_drv.oe[4];
  endproperty
  a_od_release: assert property (p_od_release) else $error("shared pin not released");

  property p_dir_mirror;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> port_a_direction == $past(dir_q);
  endproperty
  a_dir_mirror: assert property (p_dir_mirror) else $error("direction copy stale");

  property p_latch_mirror;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> port_a_latch == $past(latch_q);
  endproperty
  a_latch_mirror: assert property (p_latch_mirror) else $error("latch copy stale");

  property p_dir_write;
    @(posedge clk_sys) disable iff (rst)
    core_req.dir_wr |=> dir_q == $past(core_req.dir_wdata);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  property p_cfg_write;
    @(posedge clk_sys) disable iff (rst)
    core_req.cfg_wr |=> cfg_q == $past(core_req.cfg_wdata);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

  property p_tclk_gate;
    @(posedge clk_sys) disable iff (rst)
    !timer_ext_clk_en |=> !timer_external_clock_input;
  endproperty
  a_tclk_gate: assert property (p_tclk_gate) else $error("timer clock leaks");

  property p_tclk_follow;
    @(posedge clk_sys) disable iff (rst)
    timer_ext_clk_en |=> timer_external_clock_input == $past(pins_sync[4]);
  endproperty
  a_tclk_follow: assert property (p_tclk_follow) else $error("timer clock not from pin");

  property p_read_digital;
    @(posedge clk_sys) disable iff (rst)
    cfg_q[3] |=> port_a_data[3] == $past(pins_sync[3]);
  endproperty
  a_read_digital: assert property (p_read_digital) else $error("digital read wrong");

  property p_out_follow;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> pin_drv.out[3:0] == $past(latch_q[3:0]);
  endproperty
  a_out_follow: assert property (p_out_follow) else $error("pin output not latch");

  property p_oe_follow;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> pin_drv.oe[3:0] == ~$past(dir_q[3:0]);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("enable not from direction");

  property p_analog_mask;
    @(posedge clk_sys) disable iff (rst)
    !cfg_q[0] |=> port_a_data[0] == 1'b0;
  endproperty
  a_analog_mask: assert property (p_analog_mask) else $error("analog bit not masked");

  property p_latch_write;
    @(posedge clk_sys) disable iff (rst)
    (core_req.data_wr && core_req.data_wmask == 5'h1F) |=> latch_q == $past(core_req.data_wval);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch write lost");

  c_write: cover property (@(posedge clk_sys) disable iff (rst) core_req.data_wr);
  c_analog_out: cover property (@(posedge clk_sys) disable iff (rst) analog_sel[0] && pin_drv.oe[0]);
  c_output: cover property (@(posedge clk_sys) disable iff (rst) pin_drv.oe[0]);
  c_digital: cover property (@(posedge clk_sys) disable iff (rst) !analog_sel[1] && port_a_data[1]);
  c_timer: cover property (@(posedge clk_sys) disable iff (rst) timer_external_clock_input);

endmodule

// >>> verif/gpa_board.sv
`timescale 1ns/1ps
// board circuitry on the port pins: a pull-up on every pin plus an optional drive
module gpa_board (
  input  wire gpa_pkg::gpa_pin_drv_s pin_drv, // device drive
  input  wire logic [4:0]            brd_oe,  // board drives pin
  input  wire logic [4:0]            brd_val, // board level
  output logic [4:0]                 pin_lvl  // resolved level
);
  // a pin released by both device and board floats up to its pull-up, so stale values never linger
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pin_drv.oe[i])
        pin_lvl[i] = pin_drv.out[i];
      else if (brd_oe[i])
        pin_lvl[i] = brd_val[i];
      else
        pin_lvl[i] = 1'b1;
    end
  end
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                   clk_sys;
  logic                   rst;
  gpa_pkg::gpa_core_req_s core_req;
  logic                   timer_ext_clk_en;
  logic [4:0]             brd_oe;
  logic [4:0]             brd_val;
  logic [4:0]             pin_lvl;
  gpa_pkg::gpa_pin_drv_s  pin_drv;
  logic [4:0]             port_a_data;
  logic [4:0]             port_a_direction;
  logic [4:0]             port_a_latch;
  logic [3:0]             analog_sel;
  logic                   tclk;
  int                     fail_count;
  int                     n_tests;
  int                     cyc;

  gpa_port u_gpa_port (.clk_sys(clk_sys), .rst(rst), .core_req(core_req),
    .timer_ext_clk_en(timer_ext_clk_en), .pin_in(pin_lvl), .pin_drv(pin_drv),
    .port_a_data(port_a_data), .port_a_direction(port_a_direction),
    .port_a_latch(port_a_latch), .analog_sel(analog_sel),
    .timer_external_clock_input(tclk));
  gpa_board u_gpa_board (.pin_drv(pin_drv), .brd_oe(brd_oe), .brd_val(brd_val),
    .pin_lvl(pin_lvl));

  // 100 MHz core clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard, well above the roughly 120 cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one-cycle write pulse, then room for sync and mirror latency
  task automatic put(input gpa_pkg::gpa_core_req_s r);
    @(negedge clk_sys);
    core_req = r;
    @(negedge clk_sys);
    core_req = '0;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic wr_dir(input logic [4:0] d);
    gpa_pkg::gpa_core_req_s r;
    r = '0;
    r.dir_wr = 1'b1;
    r.dir_wdata = d;
    put(r);
  endtask
  task automatic wr_cfg(input logic [3:0] c);
    gpa_pkg::gpa_core_req_s r;
    r = '0;
    r.cfg_wr = 1'b1;
    r.cfg_wdata = c;
    put(r);
  endtask
  task automatic wr_dat(input logic [4:0] m, input logic [4:0] v);
    gpa_pkg::gpa_core_req_s r;
    r = '0;
    r.data_wr = 1'b1;
    r.data_wmask = m;
    r.data_wval = v;
    put(r);
  endtask
  task automatic brd(input logic [4:0] oe, input logic [4:0] v, input logic te);
    @(negedge clk_sys);
    brd_oe = oe;
    brd_val = v;
    timer_ext_clk_en = te;
    repeat (5) @(negedge clk_sys);
  endtask

  task automatic t_reset();
    chk(port_a_direction, 5'h1F);
    chk(port_a_latch, 5'h00);
    chk({1'b0, analog_sel}, 5'h0F);
    chk(pin_drv.oe, 5'h00);
    chk(port_a_data, 5'h10);
    $display("done reset");
  endtask
  task automatic t_read();
    brd(5'h1F, 5'h1A, 1'b0);
    chk(port_a_data, 5'h10);
    wr_cfg(4'hF);
    chk(port_a_data, 5'h1A);
    wr_cfg(4'h5);
    chk(port_a_data, 5'h10);
    chk({1'b0, analog_sel}, 5'h0A);
    $display("done read");
  endtask
  task automatic t_drive();
    wr_cfg(4'hF);
    brd(5'h00, 5'h00, 1'b0);
    wr_dir(5'h10);
    chk(port_a_direction, 5'h10);
    wr_dat(5'h0F, 5'h05);
    chk(pin_drv.oe, 5'h0F);
    chk(pin_drv.out, 5'h05);
    chk(port_a_latch, 5'h15);
    chk(port_a_data, 5'h15);
    $display("done drive");
  endtask
  task automatic t_rmw();
    wr_dir(5'h1F);
    brd(5'h1F, 5'h0A, 1'b0);
    chk(pin_drv.oe, 5'h00);
    wr_dat(5'h01, 5'h01);
    chk(port_a_latch, 5'h0B);
    $display("done rmw");
  endtask
  task automatic t_shared();
    brd(5'h00, 5'h00, 1'b0);
    wr_dir(5'h0F);
    chk(pin_drv.oe, 5'h10);
    chk(port_a_data, 5'h0F);
    brd(5'h00, 5'h00, 1'b1);
    chk(pin_drv.oe, 5'h00);
    chk({4'h0, tclk}, 5'h01);
    brd(5'h10, 5'h00, 1'b1);
    chk({4'h0, tclk}, 5'h00);
    brd(5'h00, 5'h00, 1'b0);
    wr_cfg(4'h0);
    wr_dir(5'h00);
    chk(pin_drv.oe, 5'h1F);
    // inputs again on the analog pins
    wr_dir(5'h1F);
    $display("done shared");
  endtask

  // reset for five cycles, then the scenarios
  initial begin
    rst = 1'b1;
    core_req = '0;
    timer_ext_clk_en = 1'b0;
    brd_oe = 5'h00;
    brd_val = 5'h00;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    repeat (5) @(negedge clk_sys);
    t_reset();
    t_read();
    t_drive();
    t_rmw();
    t_shared();
    stop_test();
  end
endmodule
